/* design/crgc_pkg.sv */
// constants for the clock recovery loop gain configuration block
//
// Summary of operation
// (R1) Bits 7:6 of the loop configuration, reset 01, pick the pre-sync integral gain as 1x to 4x Ki.
// (R2) Bits 5:4, reset 10, pick the pre-sync proportional gain as 1x to 4x Kp.
// (R3) Bit 3, reset 1, makes the post-sync integral gain Ki/2 when set, else keeps the pre-sync one.
// (R4) Bit 2, reset 1, makes the post-sync proportional gain Kp when set, else keeps the pre-sync one.
// (R5) Bits 1:0, reset 00, set the saturation point of data rate offset compensation.
// (R6) Saturation code 00 disables compensation and 01, 10, 11 allow 3.125, 6.25 and 12.5 percent.
// (R7) With the gating bit set, both loops stay frozen until carrier sense has been seen.
// (R8) Each new reception starts on the pre-sync gains unless sync asserts in its start cycle, and moves to post-sync in the cycle sync asserts.
package crgc_pkg;
	//----------------------------------------------------------------
	// register map
	//----------------------------------------------------------------
	localparam logic [7:0] CRGC_OFS_CONFIG = 8'h00;
	localparam logic [7:0] CRGC_OFS_CONTROL = 8'h04;
	localparam logic [7:0] CRGC_OFS_STATUS = 8'h08;
	localparam logic [7:0] CRGC_CONFIG_RESET = 8'h6c;
	localparam logic [7:0] CRGC_CONTROL_RESET = 8'h20;
	//----------------------------------------------------------------
	// field positions
	//----------------------------------------------------------------
	localparam int CRGC_PRE_KI_LSB = 6;
	localparam int CRGC_PRE_KP_LSB = 4;
	localparam int CRGC_POST_KI_BIT = 3;
	localparam int CRGC_POST_KP_BIT = 2;
	localparam int CRGC_LIMIT_LSB = 0;
	localparam int CRGC_FREEZE_BIT = 5;
	//----------------------------------------------------------------
	// saturation limits in eighths of a percent
	//----------------------------------------------------------------
	localparam logic [6:0] CRGC_LIMIT_NONE = 7'h00;
	localparam logic [6:0] CRGC_LIMIT_3P125 = 7'h19;
	localparam logic [6:0] CRGC_LIMIT_6P25 = 7'h32;
	localparam logic [6:0] CRGC_LIMIT_12P5 = 7'h64;
	// gain multiples: integral in halves of ki, proportional in kp
	localparam logic [3:0] CRGC_KI_HALF = 4'h1;
	localparam logic [2:0] CRGC_KP_BASE = 3'h1;
	//----------------------------------------------------------------
	// ahb codes
	//----------------------------------------------------------------
	localparam logic [1:0] CRGC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] CRGC_HTRANS_SEQ = 2'h3;
endpackage

/* design/crgc_top.sv */
// register slave and gain selection for the clock recovery loop
//
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
module crgc_top
	import crgc_pkg::*;
(
	input wire logic CLK, // 50 mhz clock
	input wire logic RST_N, // async reset, active low
	input wire logic HSEL, // ahb slave select
	input wire logic [31:0] HADDR, // ahb address
	input wire logic [1:0] HTRANS, // ahb transfer type
	input wire logic HWRITE, // ahb write
	input wire logic [2:0] HSIZE, // ahb size, word only
	input wire logic [31:0] HWDATA, // ahb write data
	input wire logic HREADY, // ahb bus ready
	output logic [31:0] HRDATA, // ahb read data
	output logic HREADYOUT, // ahb ready out
	output logic HRESP, // ahb response
	input wire logic RX_START, // pulse, new reception begins
	input wire logic SYNC_DET, // sync word detected
	input wire logic CARRIER_SENSE, // carrier sense indication
	output logic [3:0] INTEG_GAIN, // integral gain in halves of ki
	output logic [2:0] PROP_GAIN, // proportional gain in kp
	output logic RATE_COMP_EN, // rate offset compensation on
	output logic [6:0] RATE_LIMIT, // limit in eighths of a percent
	output logic LOOP_FREEZE // freeze offset and clock loops
);
	//----------------------------------------------------------------
	// state
	//----------------------------------------------------------------
	logic [7:0] config_r, config_nxt;
	logic loop_freeze_until_carrier_r, loop_freeze_until_carrier_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic synced_r, synced_nxt;
	logic carrier_seen_r, carrier_seen_nxt;
	logic addr_ok;
	logic post_active;
	logic [1:0] presync_integral_gain_sel;
	logic [1:0] presync_proportional_gain_sel;
	logic postsync_integral_gain_sel;
	logic postsync_proportional_gain_sel;
	logic [1:0] rate_offset_saturation_sel;
	logic [3:0] pre_ki;
	logic [2:0] pre_kp;
	logic [6:0] limit_dec;

	// decode of the saturation code
	function automatic logic [6:0] crgc_limit(input logic [1:0] code);
		case (code)
			2'h0: crgc_limit = CRGC_LIMIT_NONE;
			2'h1: crgc_limit = CRGC_LIMIT_3P125;
			2'h2: crgc_limit = CRGC_LIMIT_6P25;
			default: crgc_limit = CRGC_LIMIT_12P5;
		endcase
	endfunction

	//----------------------------------------------------------------
	// field split
	//----------------------------------------------------------------
	assign presync_integral_gain_sel = config_r[CRGC_PRE_KI_LSB +: 2]; // R1
	assign presync_proportional_gain_sel = config_r[CRGC_PRE_KP_LSB +: 2]; // R2
	assign postsync_integral_gain_sel = config_r[CRGC_POST_KI_BIT]; // R3
	assign postsync_proportional_gain_sel = config_r[CRGC_POST_KP_BIT]; // R4
	assign rate_offset_saturation_sel = config_r[CRGC_LIMIT_LSB +: 2]; // R5

	//----------------------------------------------------------------
	// ahb slave
	//----------------------------------------------------------------
	assign addr_ok = HSEL && HREADY &&
		(HTRANS == CRGC_HTRANS_NONSEQ || HTRANS == CRGC_HTRANS_SEQ);

	// address phase capture, read data and data phase write
	always_comb begin
		wr_pend_nxt = addr_ok && HWRITE;
		wr_addr_nxt = addr_ok ? HADDR[7:0] : wr_addr_r;
		hrdata_nxt = hrdata_r;
		config_nxt = config_r;
		loop_freeze_until_carrier_nxt = loop_freeze_until_carrier_r;
		if (wr_pend_r) begin
			case (wr_addr_r)
				CRGC_OFS_CONFIG: config_nxt = HWDATA[7:0];
				CRGC_OFS_CONTROL: loop_freeze_until_carrier_nxt =
					HWDATA[CRGC_FREEZE_BIT];
				default: ;
			endcase
		end
		if (addr_ok && !HWRITE) begin
			case (HADDR[7:0])
				CRGC_OFS_CONFIG: hrdata_nxt = {24'h000000, config_nxt};
				CRGC_OFS_CONTROL: hrdata_nxt = {26'h0000000,
					loop_freeze_until_carrier_nxt, 5'h00};
				CRGC_OFS_STATUS: hrdata_nxt = {20'h00000, LOOP_FREEZE,
					post_active, PROP_GAIN, INTEG_GAIN, 1'b0, carrier_seen_r,
					synced_r};
				default: hrdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			config_r <= CRGC_CONFIG_RESET;
			loop_freeze_until_carrier_r <= CRGC_CONTROL_RESET[CRGC_FREEZE_BIT];
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_r <= 32'h00000000;
		end else begin
			config_r <= config_nxt;
			loop_freeze_until_carrier_r <= loop_freeze_until_carrier_nxt;
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end

	assign HRDATA = hrdata_r;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	//----------------------------------------------------------------
	// reception tracking
	//----------------------------------------------------------------
	// a new reception clears both flags, a same-cycle event still sets
	always_comb begin
		synced_nxt = synced_r;
		carrier_seen_nxt = carrier_seen_r;
		if (RX_START) begin
			synced_nxt = 1'b0; // R8
			carrier_seen_nxt = 1'b0;
		end
		if (SYNC_DET)
			synced_nxt = 1'b1; // R8
		if (CARRIER_SENSE)
			carrier_seen_nxt = 1'b1; // R7
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			synced_r <= 1'b0;
			carrier_seen_r <= 1'b0;
		end else begin
			synced_r <= synced_nxt;
			carrier_seen_r <= carrier_seen_nxt;
		end
	end

	//----------------------------------------------------------------
	// gain and limit selection
	//----------------------------------------------------------------
	// post-sync gains apply from the sync cycle itself
	assign post_active = (synced_r && !RX_START) || SYNC_DET; // R8
	assign pre_ki = {1'b0, presync_integral_gain_sel, 1'b0} + 4'h2; // R1
	assign pre_kp = {1'b0, presync_proportional_gain_sel} + 3'h1; // R2
	assign limit_dec = crgc_limit(rate_offset_saturation_sel); // R6

	always_comb begin
		INTEG_GAIN = pre_ki;
		PROP_GAIN = pre_kp;
		if (post_active && postsync_integral_gain_sel)
			INTEG_GAIN = CRGC_KI_HALF; // R3
		if (post_active && postsync_proportional_gain_sel)
			PROP_GAIN = CRGC_KP_BASE; // R4
	end

	assign RATE_LIMIT = limit_dec; // R5
	assign RATE_COMP_EN = (rate_offset_saturation_sel != 2'h0); // R6
	// frozen until carrier sense, which releases in its own cycle
	assign LOOP_FREEZE = loop_freeze_until_carrier_r &&
		!carrier_seen_r && !CARRIER_SENSE; // R7

	//----------------------------------------------------------------
	// checks
	//----------------------------------------------------------------
	default clocking crgc_cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// gain mapping before sync and after it
	a_pre_ki_map: assert property (!post_active |-> // R1
		INTEG_GAIN == 4'h2 * {2'h0, config_r[7:6]} + 4'h2)
		else $error("pre-sync integral gain wrong");
	a_pre_kp_map: assert property (!post_active |-> // R2
		PROP_GAIN == {1'b0, config_r[5:4]} + 3'h1)
		else $error("pre-sync proportional gain wrong");
	a_post_ki_sel: assert property (post_active |-> // R3
		(config_r[3] ? INTEG_GAIN == 4'h1 :
		INTEG_GAIN == {1'b0, config_r[7:6], 1'b0} + 4'h2))
		else $error("post-sync integral gain wrong");
	a_post_kp_sel: assert property (post_active |-> // R4
		(config_r[2] ? PROP_GAIN == 3'h1 :
		PROP_GAIN == {1'b0, config_r[5:4]} + 3'h1))
		else $error("post-sync proportional gain wrong");
	// register writes land one edge after their data phase
	a_cfg_write: assert property ( // R5
		wr_pend_r && wr_addr_r == CRGC_OFS_CONFIG |=>
		config_r == $past(HWDATA[7:0]))
		else $error("config write not stored");
	a_ctl_write: assert property ( // R7
		wr_pend_r && wr_addr_r == CRGC_OFS_CONTROL |=>
		loop_freeze_until_carrier_r == $past(HWDATA[CRGC_FREEZE_BIT]))
		else $error("control write not stored");
	// each saturation code against its limit
	a_limit_dec: assert property ( // R6
		(RATE_COMP_EN == (config_r[1:0] != 2'h0)) &&
		(config_r[1:0] != 2'h0 || RATE_LIMIT == 7'h00) &&
		(config_r[1:0] != 2'h1 || RATE_LIMIT == 7'h19) &&
		(config_r[1:0] != 2'h2 || RATE_LIMIT == 7'h32) &&
		(config_r[1:0] != 2'h3 || RATE_LIMIT == 7'h64))
		else $error("saturation decode wrong");
	// freeze follows the gating bit until carrier sense is seen
	a_freeze_hold: assert property ( // R7
		loop_freeze_until_carrier_r && RX_START && !CARRIER_SENSE ##1
		!CARRIER_SENSE[*2] |-> LOOP_FREEZE == loop_freeze_until_carrier_r)
		else $error("loops not frozen before carrier");
	a_rx_freeze: assert property ( // R7
		RX_START && !CARRIER_SENSE |=>
		CARRIER_SENSE || LOOP_FREEZE == loop_freeze_until_carrier_r)
		else $error("gating not rearmed by new reception");
	a_freeze_free: assert property ( // R7
		CARRIER_SENSE |-> !LOOP_FREEZE ##1 (RX_START || !LOOP_FREEZE))
		else $error("loops frozen after carrier");
	// sync switching and reception restart
	a_sync_switch: assert property ( // R8
		SYNC_DET ##1 !RX_START[*3] |-> $past(post_active, 3) && post_active)
		else $error("post-sync gains not held");
	a_rx_restart: assert property ( // R8
		RX_START && !SYNC_DET |-> !post_active)
		else $error("new reception not on pre-sync gains");
endmodule

/* sim/crgc_rx_model.sv */
// receiver front end model driving the reception indications
`timescale 1ns/1ps
module crgc_rx_model (
	input wire logic clk, // modem clock
	output logic rx_start, // new reception pulse
	output logic sync_det, // sync word found
	output logic carrier_sense // carrier present
);
	// quiet lines until the first reception
	initial begin
		rx_start = 1'b0;
		sync_det = 1'b0;
		carrier_sense = 1'b0;
	end
	// one-cycle start pulse, both indications dropped with it
	task automatic begin_rx();
		@(posedge clk);
		rx_start <= 1'b1;
		sync_det <= 1'b0;
		carrier_sense <= 1'b0;
		@(posedge clk);
		rx_start <= 1'b0;
	endtask
	// level change of sync and carrier, right after an edge
	task automatic set_ind(input logic s, input logic c);
		@(posedge clk);
		sync_det <= s;
		carrier_sense <= c;
	endtask
endmodule

/* sim/crgc_top_tb.sv */
// self-checking bench for the clock recovery gain configuration
`timescale 1ns/1ps
module crgc_top_tb
	import crgc_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, rx_start, sync_det, carrier_sense, comp_en, freeze;
	logic [3:0] ig;
	logic [2:0] pg;
	logic [6:0] lim;
	int errors = 0;
	int tests_run = 0;
	always #10 clk = ~clk;
	crgc_top crgc_top_inst (.CLK(clk), .RST_N(rst_n), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .RX_START(rx_start),
		.SYNC_DET(sync_det), .CARRIER_SENSE(carrier_sense), .INTEG_GAIN(ig),
		.PROP_GAIN(pg), .RATE_COMP_EN(comp_en), .RATE_LIMIT(lim),
		.LOOP_FREEZE(freeze));
	crgc_rx_model crgc_rx_model_inst (.clk(clk), .rx_start(rx_start),
		.sync_det(sync_det), .carrier_sense(carrier_sense));
	//----------------------------------------------------------------
	// bus and compare tasks
	//----------------------------------------------------------------
	// single word transfer, each phase held until hready is seen
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= CRGC_HTRANS_NONSEQ;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string w);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, w, got, exp);
		end
	endtask
	// gain outputs, checked mid-cycle
	task automatic chk_g(input logic [3:0] i, input logic [2:0] p, string w);
		@(negedge clk);
		chk({28'h0, ig}, {28'h0, i}, w);
		chk({29'h0, pg}, {29'h0, p}, w);
	endtask
	//----------------------------------------------------------------
	// scenarios
	//----------------------------------------------------------------
	task automatic test_reset();
		chk_g(4'h4, 3'h3, "reset gains");
		chk({24'h0, comp_en, lim}, 32'h0, "reset limit");
		chk({31'h0, freeze}, 32'h1, "reset freeze");
		ahb(1'b0, CRGC_OFS_CONFIG, 32'h0);
		chk(rd, 32'h6c, "config reset");
		chk({31'h0, hresp}, 32'h0, "okay response");
		ahb(1'b0, CRGC_OFS_CONTROL, 32'h0);
		chk(rd, 32'h20, "control reset");
		ahb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		$display("reset test done");
	endtask
	// every code of the pre-gain and saturation fields, post bits clear keep pre gains
	task automatic test_fields();
		logic [6:0] tl [4] = '{7'h00, 7'h19, 7'h32, 7'h64};
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, CRGC_OFS_CONFIG, {24'h0, i[1:0], i[1:0], 2'b00, i[1:0]});
			chk_g(4'(2 * i + 2), 3'(i + 1), "pre gains");
			chk({24'h0, comp_en, lim}, {24'h0, i != 0, tl[i]}, "limit");
			crgc_rx_model_inst.set_ind(1'b1, 1'b0);
			chk_g(4'(2 * i + 2), 3'(i + 1), "post same as pre");
			crgc_rx_model_inst.begin_rx();
		end
		$display("field test done");
	endtask
	task automatic test_sync();
		ahb(1'b1, CRGC_OFS_CONFIG, 32'hdc);
		crgc_rx_model_inst.begin_rx();
		chk_g(4'h8, 3'h2, "pre gains");
		crgc_rx_model_inst.set_ind(1'b1, 1'b0);
		chk_g(4'h1, 3'h1, "post gains at sync");
		crgc_rx_model_inst.set_ind(1'b0, 1'b0);
		chk_g(4'h1, 3'h1, "post gains held");
		ahb(1'b0, CRGC_OFS_STATUS, 32'h0);
		chk(rd, 32'h00000c89, "status after sync");
		crgc_rx_model_inst.begin_rx();
		chk_g(4'h8, 3'h2, "new reception");
		$display("sync test done");
	endtask
	task automatic test_freeze();
		crgc_rx_model_inst.begin_rx();
		@(negedge clk);
		chk({31'h0, freeze}, 32'h1, "frozen");
		crgc_rx_model_inst.set_ind(1'b0, 1'b1);
		@(negedge clk);
		chk({31'h0, freeze}, 32'h0, "released by carrier");
		crgc_rx_model_inst.set_ind(1'b0, 1'b0);
		@(negedge clk);
		chk({31'h0, freeze}, 32'h0, "stays released");
		ahb(1'b1, CRGC_OFS_CONTROL, 32'h0);
		crgc_rx_model_inst.begin_rx();
		@(negedge clk);
		chk({31'h0, freeze}, 32'h0, "gating off");
		$display("freeze test done");
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// main sequence after a 20 cycle reset
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		test_reset();
		test_fields();
		test_sync();
		test_freeze();
		final_report();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		final_report();
	end
endmodule
